//--- hw/tdr_top.sv
`timescale 1ns/100ps
// Overview of operation
// - opcodes a and b route to debug
// - port works only if fuse on, disable clear
// - locked part refuses debug fuse until erase
// - cpu mailbox write stores byte, sets dirty
// - cpu read: seven data bits, dirty on top
// - shared address reaches mailbox only when enabled
// - power-up instruction is idcode
// - chip reset floats all pin drivers, except under extest
// - extest drives output latches at once
// - sample/preload snapshots pins without disturbance
// - boundary scan runs on test clock alone
// - bypass is one stage, zero on capture
// - id word: version, part, manufacturer fields
// - version field counts silicon revisions from zero
// - reset register one holds chip in reset
// - reset time-out follows register release
// - reset register output is unlatched
// - chain drives and observes pins, analog edge; chain here has cells for the digital pins only
// - four-bit ir with fixed public opcodes
// - reset instruction leaves tap controller alone
// - all shift registers move lsb first
// - tap reset flag, cleared by por or zero write
module tdr_top
    import tdr_pkg::*;
#(
    parameter int N_PINS = 8,
    parameter logic [3:0] ID_VERSION = 4'h0, // first silicon
    parameter logic [15:0] ID_PART = 16'h1234, // value arbitrary
    parameter logic [10:0] ID_MFR = 11'h055, // value arbitrary
    parameter int TOUT_SHORT = TOUT_SHORT_CYC,
    parameter int TOUT_LONG = TOUT_LONG_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_ff,
    output logic tdo_oe_ff,
    input wire logic tap_enable_fuse,
    input wire logic debug_enable_fuse,
    input wire logic lock_bit_one,
    input wire logic lock_bit_two,
    input wire logic clk_opt_long,
    input wire logic fuse_wr_req,
    input wire logic chip_erase_done,
    input wire tdr_pkg::tdr_io_req_t io_req,
    output tdr_pkg::tdr_io_rsp_t io_rsp_ff,
    output logic fuse_wr_grant_ff,
    output logic fuse_wr_refused_ff,
    output logic [1:0] ocd_sel_ff,
    output tdr_pkg::tdr_dr_ctl_t ocd_ctl_ff,
    input wire logic ocd_tdo,
    output logic chip_rst_hold,
    input wire logic [N_PINS-1:0] sys_pin_out,
    input wire logic [N_PINS-1:0] sys_pin_oe,
    input wire logic [N_PINS-1:0] pad_in,
    output logic [N_PINS-1:0] pad_out,
    output logic [N_PINS-1:0] pad_oe
);
    localparam int TCW = $clog2(TOUT_LONG + 1);

    // ---- test clock domain
    tdr_tap_state_t st_ff, nxt_st;
    logic [IR_W-1:0] ir_ff, nxt_ir, ir_sr_ff, nxt_ir_sr;
    logic [ID_W-1:0] sr_ff, nxt_sr;
    logic rstreg_ff, nxt_rstreg, acc_en_ff, nxt_acc_en, clr_tog_ff, nxt_clr_tog;
    logic [7:0] mbox_hold_ff, nxt_mbox_hold;
    logic dirty_seen_ff, nxt_dirty_seen;
    logic nxt_tdo, nxt_tdo_oe;
    logic [1:0] nxt_ocd_sel;
    tdr_dr_ctl_t dr_ctl, nxt_ocd_ctl;
    logic tap_en_t, dirty_t, bs_sel, priv_ext, bs_tdo;
    int unsigned dr_len;

    // ---- chip clock domain
    logic [7:0] mbox_ff, nxt_mbox;
    logic dirty_ff, nxt_dirty, tapdis_ff, nxt_tapdis, taprst_flag_ff, nxt_taprst_flag;
    logic twr_pend_ff, nxt_twr_pend, twr_val_ff, nxt_twr_val;
    logic [2:0] twr_cnt_ff, nxt_twr_cnt;
    logic erase_seen_ff, nxt_erase_seen, nxt_grant, nxt_refused;
    logic [TCW-1:0] tout_ff, nxt_tout;
    logic stretch_ff, nxt_stretch, clr_d_ff;
    tdr_io_rsp_t nxt_rsp;
    logic acc_en_r, clr_tog_r, rstreg_r, mbox_on, hit_mbox, hit_ctl, hit_stat;

    function automatic tdr_tap_state_t tap_next(tdr_tap_state_t s, logic m);
        unique case (s)
            TS_RESET: tap_next = m ? TS_RESET : TS_IDLE;
            TS_IDLE: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: tap_next = m ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: tap_next = m ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: tap_next = m ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: tap_next = m ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: tap_next = m ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: tap_next = m ? TS_UPD_DR : TS_SHIFT_DR;
            TS_UPD_DR: tap_next = m ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: tap_next = m ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: tap_next = m ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: tap_next = m ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: tap_next = m ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: tap_next = m ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: tap_next = m ? TS_UPD_IR : TS_SHIFT_IR;
            TS_UPD_IR: tap_next = m ? TS_SEL_DR : TS_IDLE;
        endcase
    endfunction : tap_next

    // length of the internal shared shift register per instruction
    function automatic int unsigned dr_width(logic [IR_W-1:0] ir);
        unique case (ir)
            IR_IDCODE: dr_width = ID_W;
            IR_PRIV_A: dr_width = MBOX_DR_W;
            default: dr_width = 1;
        endcase
    endfunction : dr_width

    tdr_sync #(.W(2)) u_sync_t (
        .clk(tck),
        .rst_b(rst_b),
        .d({tap_enable_fuse & ~tapdis_ff, dirty_ff}),
        .q({tap_en_t, dirty_t})
    );

    assign bs_sel = (ir_ff == IR_EXTEST) || (ir_ff == IR_SAMPLE);
    assign priv_ext = (ir_ff == IR_PRIV_C) || (ir_ff == IR_PRIV_D);
    assign dr_len = dr_width(ir_ff);
    assign dr_ctl.capture = (st_ff == TS_CAP_DR);
    assign dr_ctl.shift = (st_ff == TS_SHIFT_DR);
    assign dr_ctl.update = (st_ff == TS_UPD_DR);

    tdr_bscan #(.N_PINS(N_PINS)) u_bscan (
        .tck(tck),
        .rst_b(rst_b),
        .ctl(bs_sel ? dr_ctl : tdr_dr_ctl_t'('0)),
        .extest(ir_ff == IR_EXTEST),
        .tdi(tdi),
        .tdo(bs_tdo),
        .sys_out(sys_pin_out),
        .sys_oe(sys_pin_oe),
        .pad_in(pad_in),
        .chip_rst(chip_rst_hold),
        .pad_out(pad_out),
        .pad_oe(pad_oe)
    );

    always_comb
    begin
        nxt_st = tap_en_t ? tap_next(st_ff, tms) : TS_RESET;
        nxt_ir = ir_ff;
        nxt_ir_sr = ir_sr_ff;
        nxt_sr = sr_ff;
        nxt_rstreg = rstreg_ff;
        nxt_acc_en = acc_en_ff;
        nxt_clr_tog = clr_tog_ff;
        nxt_mbox_hold = mbox_hold_ff;
        nxt_dirty_seen = dirty_t;
        if (dirty_t && !dirty_seen_ff)
            nxt_mbox_hold = mbox_ff; // word stable since dirty rose
        unique case (st_ff)
            TS_RESET:
            begin
                nxt_ir = IR_IDCODE;
                nxt_rstreg = 1'b0;
                nxt_acc_en = 1'b0;
            end
            TS_CAP_IR: nxt_ir_sr = IR_CAPTURE;
            TS_SHIFT_IR: nxt_ir_sr = {tdi, ir_sr_ff[IR_W-1:1]};
            TS_UPD_IR: nxt_ir = ir_sr_ff;
            TS_CAP_DR:
            begin
                unique case (ir_ff)
                    IR_IDCODE: nxt_sr = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
                    IR_PRIV_A: nxt_sr = {23'h0, dirty_t, mbox_hold_ff};
                    default: nxt_sr = '0;
                endcase
            end
            TS_SHIFT_DR:
            begin
                if (ir_ff == IR_CHIPRST)
                    nxt_rstreg = tdi;
                nxt_sr = sr_ff >> 1;
                nxt_sr[dr_len-1] = tdi;
            end
            TS_UPD_DR:
            begin
                if (ir_ff == IR_PRIV_A && sr_ff[MBOX_DR_W-1])
                    nxt_clr_tog = ~clr_tog_ff;
                if (ir_ff == IR_PRIV_B)
                    nxt_acc_en = sr_ff[0];
            end
            default: ;
        endcase
        nxt_ocd_sel = ir_ff[1:0];
        nxt_ocd_ctl = '0;
        if (priv_ext)
        begin
            nxt_ocd_ctl.capture = (nxt_st == TS_CAP_DR);
            nxt_ocd_ctl.shift = (nxt_st == TS_SHIFT_DR);
            nxt_ocd_ctl.update = (nxt_st == TS_UPD_DR);
        end
    end

    // tdo launches on falling tck
    always_comb
    begin
        nxt_tdo_oe = (st_ff == TS_SHIFT_IR) || (st_ff == TS_SHIFT_DR);
        nxt_tdo = 1'b0;
        if (st_ff == TS_SHIFT_IR)
            nxt_tdo = ir_sr_ff[0];
        else if (st_ff == TS_SHIFT_DR)
        begin
            if (bs_sel)
                nxt_tdo = bs_tdo;
            else if (ir_ff == IR_CHIPRST)
                nxt_tdo = rstreg_ff;
            else if (priv_ext)
                nxt_tdo = ocd_tdo;
            else
                nxt_tdo = sr_ff[0];
        end
    end

    always_ff @(posedge tck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= TS_RESET;
            ir_ff <= IR_IDCODE;
            ir_sr_ff <= '0;
            sr_ff <= '0;
            rstreg_ff <= 1'b0;
            acc_en_ff <= 1'b0;
            clr_tog_ff <= 1'b0;
            mbox_hold_ff <= '0;
            dirty_seen_ff <= 1'b0;
            ocd_sel_ff <= '0;
            ocd_ctl_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
            ir_ff <= nxt_ir;
            ir_sr_ff <= nxt_ir_sr;
            sr_ff <= nxt_sr;
            rstreg_ff <= nxt_rstreg;
            acc_en_ff <= nxt_acc_en;
            clr_tog_ff <= nxt_clr_tog;
            mbox_hold_ff <= nxt_mbox_hold;
            dirty_seen_ff <= nxt_dirty_seen;
            ocd_sel_ff <= nxt_ocd_sel;
            ocd_ctl_ff <= nxt_ocd_ctl;
        end
    end

    always_ff @(negedge tck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end
        else
        begin
            tdo_ff <= nxt_tdo;
            tdo_oe_ff <= nxt_tdo_oe;
        end
    end

    // ---- chip clock side
    tdr_sync #(.W(3)) u_sync_r (
        .clk(ref_clk),
        .rst_b(rst_b),
        .d({acc_en_ff, clr_tog_ff, rstreg_ff}),
        .q({acc_en_r, clr_tog_r, rstreg_r})
    );

    assign mbox_on = debug_enable_fuse & acc_en_r;
    assign hit_mbox = (io_req.addr == IO_MBOX_ADDR) && mbox_on;
    assign hit_ctl = (io_req.addr == IO_SYSCTL_ADDR);
    assign hit_stat = (io_req.addr == IO_SYSSTAT_ADDR);

    always_comb
    begin
        nxt_mbox = mbox_ff;
        nxt_dirty = dirty_ff;
        if (clr_tog_r != clr_d_ff)
            nxt_dirty = 1'b0;
        if (io_req.wr && hit_mbox)
        begin
            nxt_mbox = io_req.wdata;
            nxt_dirty = 1'b1;
        end
        nxt_taprst_flag = taprst_flag_ff;
        if (io_req.wr && hit_stat && !io_req.wdata[SYSSTAT_TAPRST_BIT])
            nxt_taprst_flag = 1'b0;
        if (rstreg_r)
            nxt_taprst_flag = 1'b1;
        // disable bit changes only on two equal writes within the window
        nxt_tapdis = tapdis_ff;
        nxt_twr_pend = twr_pend_ff;
        nxt_twr_val = twr_val_ff;
        nxt_twr_cnt = twr_cnt_ff;
        if (twr_pend_ff)
        begin
            nxt_twr_cnt = twr_cnt_ff + 3'h1;
            if (twr_cnt_ff == 3'(TIMED_WR_WINDOW - 1))
                nxt_twr_pend = 1'b0;
        end
        if (io_req.wr && hit_ctl)
        begin
            if (twr_pend_ff && twr_val_ff == io_req.wdata[SYSCTL_TAPDIS_BIT])
            begin
                nxt_tapdis = twr_val_ff;
                nxt_twr_pend = 1'b0;
            end
            else
            begin
                nxt_twr_pend = 1'b1;
                nxt_twr_val = io_req.wdata[SYSCTL_TAPDIS_BIT];
                nxt_twr_cnt = 3'h1;
            end
        end
        nxt_rsp = '0;
        nxt_rsp.rvalid = io_req.rd && (hit_mbox || hit_ctl || hit_stat);
        if (io_req.rd && hit_mbox)
            nxt_rsp.rdata = {dirty_ff, mbox_ff[6:0]};
        else if (io_req.rd && hit_ctl)
            nxt_rsp.rdata[SYSCTL_TAPDIS_BIT] = tapdis_ff;
        else if (io_req.rd && hit_stat)
            nxt_rsp.rdata[SYSSTAT_TAPRST_BIT] = taprst_flag_ff;
        nxt_erase_seen = erase_seen_ff | chip_erase_done;
        nxt_grant = fuse_wr_req && (!(lock_bit_one || lock_bit_two) || erase_seen_ff);
        nxt_refused = fuse_wr_req && !nxt_grant;
        nxt_tout = tout_ff;
        if (rstreg_r)
            nxt_tout = clk_opt_long ? TCW'(TOUT_LONG) : TCW'(TOUT_SHORT);
        else if (tout_ff != '0)
            nxt_tout = tout_ff - TCW'(1);
        nxt_stretch = rstreg_r || (tout_ff > TCW'(1));
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mbox_ff <= MBOX_RESET;
            dirty_ff <= 1'b0;
            tapdis_ff <= TAPDIS_RESET;
            taprst_flag_ff <= 1'b0;
            twr_pend_ff <= 1'b0;
            twr_val_ff <= 1'b0;
            twr_cnt_ff <= '0;
            erase_seen_ff <= 1'b0;
            fuse_wr_grant_ff <= 1'b0;
            fuse_wr_refused_ff <= 1'b0;
            tout_ff <= '0;
            stretch_ff <= 1'b0;
            clr_d_ff <= 1'b0;
            io_rsp_ff <= '0;
        end
        else
        begin
            mbox_ff <= nxt_mbox;
            dirty_ff <= nxt_dirty;
            tapdis_ff <= nxt_tapdis;
            taprst_flag_ff <= nxt_taprst_flag;
            twr_pend_ff <= nxt_twr_pend;
            twr_val_ff <= nxt_twr_val;
            twr_cnt_ff <= nxt_twr_cnt;
            erase_seen_ff <= nxt_erase_seen;
            fuse_wr_grant_ff <= nxt_grant;
            fuse_wr_refused_ff <= nxt_refused;
            tout_ff <= nxt_tout;
            stretch_ff <= nxt_stretch;
            clr_d_ff <= clr_tog_r;
            io_rsp_ff <= nxt_rsp;
        end
    end

    // immediate on the tck flop, stretched by the chip-clock timer
    assign chip_rst_hold = rstreg_ff | stretch_ff;
endmodule : tdr_top

//--- hw/tdr_pkg.sv
package tdr_pkg;
    // instruction codes
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_PRIV_A = 4'h8;
    localparam logic [3:0] IR_PRIV_B = 4'h9;
    localparam logic [3:0] IR_PRIV_C = 4'ha;
    localparam logic [3:0] IR_PRIV_D = 4'hb;
    localparam logic [3:0] IR_CHIPRST = 4'hc;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam int IR_W = 4;
    // identification word layout
    localparam int ID_W = 32;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam int MBOX_DR_W = 9;
    // cpu i/o map
    localparam int IO_AW = 6;
    localparam logic [5:0] IO_SYSCTL_ADDR = 6'h35;
    localparam logic [5:0] IO_SYSSTAT_ADDR = 6'h34;
    localparam logic [5:0] IO_MBOX_ADDR = 6'h31;
    localparam int SYSCTL_TAPDIS_BIT = 7;
    localparam int SYSSTAT_TAPRST_BIT = 4;
    localparam int MBOX_DIRTY_BIT = 7;
    localparam logic TAPDIS_RESET = 1'b0;
    localparam logic [7:0] MBOX_RESET = 8'h00;
    // timing
    localparam int TIMED_WR_WINDOW = 4;
    localparam int CLK_KHZ = 10000;
    localparam int TOUT_SHORT_US = 4100;
    localparam int TOUT_LONG_US = 65000;
    localparam int TOUT_SHORT_CYC = (TOUT_SHORT_US * CLK_KHZ + 999) / 1000;
    localparam int TOUT_LONG_CYC = (TOUT_LONG_US * CLK_KHZ + 999) / 1000;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR, TS_PAUSE_DR,
        TS_EXIT2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR, TS_EXIT1_IR,
        TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
    } tdr_tap_state_t;

    typedef struct packed {
        logic [5:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tdr_io_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
    } tdr_io_rsp_t;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
    } tdr_dr_ctl_t;
endpackage : tdr_pkg

//--- hw/tdr_sync.sv
`timescale 1ns/100ps
module tdr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : tdr_sync

//--- hw/tdr_bscan.sv
`timescale 1ns/100ps
module tdr_bscan
    import tdr_pkg::*;
#(
    parameter int N_PINS = 8
) (
    input wire logic tck,
    input wire logic rst_b,
    input wire tdr_pkg::tdr_dr_ctl_t ctl,
    input wire logic extest,
    input wire logic tdi,
    output logic tdo,
    input wire logic [N_PINS-1:0] sys_out,
    input wire logic [N_PINS-1:0] sys_oe,
    input wire logic [N_PINS-1:0] pad_in,
    input wire logic chip_rst,
    output logic [N_PINS-1:0] pad_out,
    output logic [N_PINS-1:0] pad_oe
);
    localparam int CW = 3 * N_PINS;
    logic [CW-1:0] chain_ff;
    logic [CW-1:0] nxt_chain;
    logic [N_PINS-1:0] lat_out_ff;
    logic [N_PINS-1:0] lat_oe_ff;
    logic [N_PINS-1:0] nxt_lat_out;
    logic [N_PINS-1:0] nxt_lat_oe;
    logic [CW-1:0] obs_raw;
    logic [CW-1:0] obs;

    // cell order per pin: input, output data, output control
    always_comb
    begin
        for (int i = 0; i < N_PINS; i++)
        begin
            obs_raw[3*i] = pad_in[i];
            obs_raw[3*i+1] = sys_out[i];
            obs_raw[3*i+2] = sys_oe[i];
        end
    end

    // pins and core levels arrive unrelated to tck
    tdr_sync #(.W(CW)) u_obs_sync (
        .clk(tck),
        .rst_b(rst_b),
        .d(obs_raw),
        .q(obs)
    );

    always_comb
    begin
        nxt_chain = chain_ff;
        nxt_lat_out = lat_out_ff;
        nxt_lat_oe = lat_oe_ff;
        if (ctl.capture)
            nxt_chain = obs;
        else if (ctl.shift)
            nxt_chain = {tdi, chain_ff[CW-1:1]};
        if (ctl.update)
        begin
            for (int i = 0; i < N_PINS; i++)
            begin
                nxt_lat_out[i] = chain_ff[3*i+1];
                nxt_lat_oe[i] = chain_ff[3*i+2];
            end
        end
    end

    always_ff @(posedge tck or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chain_ff <= '0;
            lat_out_ff <= '0;
            lat_oe_ff <= '0;
        end
        else
        begin
            chain_ff <= nxt_chain;
            lat_out_ff <= nxt_lat_out;
            lat_oe_ff <= nxt_lat_oe;
        end
    end

    assign tdo = chain_ff[0];
    // pad drive must follow ir and reset without waiting for any clock
    assign pad_out = extest ? lat_out_ff : sys_out;
    assign pad_oe = extest ? lat_oe_ff : (chip_rst ? '0 : sys_oe);
endmodule : tdr_bscan

//--- verif/tdr_top_props.sv
`timescale 1ns/100ps
module tdr_top_props
    import tdr_pkg::*;
#(
    parameter int N_PINS = 8,
    parameter int TOUT_SHORT = 20
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic tap_enable_fuse,
    input wire logic debug_enable_fuse,
    input wire logic lock_bit_one,
    input wire logic lock_bit_two,
    input wire logic fuse_wr_req,
    input wire logic chip_erase_done,
    input wire tdr_pkg::tdr_io_req_t io_req,
    input wire tdr_pkg::tdr_io_rsp_t io_rsp_ff,
    input wire logic fuse_wr_grant_ff,
    input wire logic fuse_wr_refused_ff,
    input wire logic tdo_oe_ff,
    input wire logic chip_rst_hold,
    input wire logic [N_PINS-1:0] pad_oe
);
    logic erased_ff, nxt_erased;
    int hold_cnt_ff, nxt_hold_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    always_comb
    begin
        nxt_erased = erased_ff | chip_erase_done;
        nxt_hold_cnt = chip_rst_hold ? hold_cnt_ff + 1 : 0;
    end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            erased_ff <= 1'b0;
            hold_cnt_ff <= 0;
        end
        else
        begin
            erased_ff <= nxt_erased;
            hold_cnt_ff <= nxt_hold_cnt;
        end
    end
    property p_refuse;
        fuse_wr_req && (lock_bit_one || lock_bit_two) && !nxt_erased
            |=> fuse_wr_refused_ff && !fuse_wr_grant_ff;
    endproperty
    a_refuse: assert property (p_refuse) else $error("fuse write granted");
    property p_grant;
        fuse_wr_req && !lock_bit_one && !lock_bit_two |=> fuse_wr_grant_ff;
    endproperty
    a_grant: assert property (p_grant) else $error("fuse write refused");
    property p_float;
        chip_rst_hold |-> pad_oe == '0;
    endproperty
    a_float: assert property (p_float) else $error("pad driven in reset");
    property p_hold;
        $fell(chip_rst_hold) |-> hold_cnt_ff >= TOUT_SHORT;
    endproperty
    a_hold: assert property (p_hold) else $error("reset time-out short");
    property p_mbox;
        (io_req.wr && io_req.addr == IO_MBOX_ADDR) ##2 (io_req.rd && io_req.addr == IO_MBOX_ADDR)
            ##1 io_rsp_ff.rvalid |-> io_rsp_ff.rdata == {1'b1, $past(io_req.wdata[6:0], 3)};
    endproperty
    a_mbox: assert property (p_mbox) else $error("mailbox read wrong");
    property p_blocked;
        io_req.rd && io_req.addr == IO_MBOX_ADDR && !debug_enable_fuse |=> !io_rsp_ff.rvalid;
    endproperty
    a_blocked: assert property (p_blocked) else $error("mailbox reachable");
    property p_tap_off;
        !tap_enable_fuse [*3] |-> !tdo_oe_ff;
    endproperty
    a_tap_off: assert property (p_tap_off) else $error("tdo driven when off");
    property p_flag_clr;
        (io_req.wr && io_req.addr == IO_SYSSTAT_ADDR && !io_req.wdata[4] && !chip_rst_hold)
            ##2 (io_req.rd && io_req.addr == IO_SYSSTAT_ADDR) |=> !io_rsp_ff.rdata[4];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
endmodule : tdr_top_props
bind tdr_top tdr_top_props #(.N_PINS(N_PINS), .TOUT_SHORT(TOUT_SHORT)) u_tdr_top_props (
    .ref_clk, .rst_b, .tap_enable_fuse, .debug_enable_fuse, .lock_bit_one, .lock_bit_two,
    .fuse_wr_req, .chip_erase_done, .io_req, .io_rsp_ff, .fuse_wr_grant_ff,
    .fuse_wr_refused_ff, .tdo_oe_ff, .chip_rst_hold, .pad_oe);

//--- verif/tdr_dbg_host.sv
`timescale 1ns/100ps
module tdr_dbg_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo_ff,
    input wire logic tdo_oe_ff
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // tck stands low between frames; undriven tdo line pulled high
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #6;
        o = tdo_oe_ff ? tdo_ff : 1'b1;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask : step
    task automatic reset_idle();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask : reset_idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, o);
        if (ir)
            step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        tdi = 1'b1;
    endtask : scan
endmodule : tdr_dbg_host

//--- verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) \
    begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    import tdr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic tap_enable_fuse = 1'b0;
    logic debug_enable_fuse = 1'b0;
    logic lock_bit_one = 1'b0;
    logic lock_bit_two = 1'b0;
    logic fuse_wr_req = 1'b0;
    logic chip_erase_done = 1'b0;
    tdr_io_req_t io_req = '0;
    tdr_io_rsp_t io_rsp_ff, rsp;
    logic tck, tms, tdi, tdo_ff, tdo_oe_ff, fuse_wr_grant_ff, fuse_wr_refused_ff;
    logic chip_rst_hold;
    logic clk_opt_long = 1'b0, ocd_tdo = 1'b0;
    logic [1:0] ocd_sel_ff;
    logic [7:0] pad_out, pad_oe, pins;
    logic [31:0] d, pre;
    int errors = 0;
    int samples_checked = 0;
    int n;
    always #50 ref_clk = ~ref_clk;
    tdr_top #(.TOUT_SHORT(20), .TOUT_LONG(50)) u_tdr_top (.ref_clk, .rst_b, .tck, .tms, .tdi,
        .tdo_ff, .tdo_oe_ff,
        .tap_enable_fuse, .debug_enable_fuse, .lock_bit_one, .lock_bit_two, .clk_opt_long,
        .fuse_wr_req, .chip_erase_done, .io_req, .io_rsp_ff, .fuse_wr_grant_ff,
        .fuse_wr_refused_ff, .ocd_sel_ff, .ocd_ctl_ff(), .ocd_tdo, .chip_rst_hold,
        .sys_pin_out(8'ha5), .sys_pin_oe(8'hff), .pad_in(8'h3c), .pad_out, .pad_oe);
    tdr_dbg_host u_tdr_dbg_host (.tck, .tms, .tdi, .tdo_ff, .tdo_oe_ff);
    task automatic close_out();
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic io_wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge ref_clk) io_req <= '{a, 1'b1, 1'b0, v};
        @(posedge ref_clk) io_req <= '0;
    endtask : io_wr
    task automatic io_rd(input logic [5:0] a);
        @(posedge ref_clk) io_req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge ref_clk) io_req <= '0;
        #1 rsp = io_rsp_ff;
    endtask : io_rd
    task automatic poll_mbox();
        for (n = 0; n < 20; n++)
        begin
            io_rd(IO_MBOX_ADDR);
            if (rsp.rvalid === 1'b1 && rsp.rdata[MBOX_DIRTY_BIT] === 1'b0)
                return;
        end
        errors++;
        close_out();
    endtask : poll_mbox
    task automatic fuse_try(input logic g);
        @(posedge ref_clk) fuse_wr_req <= 1'b1;
        @(posedge ref_clk) fuse_wr_req <= 1'b0;
        #1 `CHK({fuse_wr_grant_ff, fuse_wr_refused_ff}, {g, !g})
    endtask : fuse_try
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        u_tdr_dbg_host.scan(1'b0, 32, 32'h0, d);
        `CHK(d, 32'hffffffff)
        @(posedge ref_clk) tap_enable_fuse <= 1'b1;
        u_tdr_dbg_host.reset_idle();
        u_tdr_dbg_host.scan(1'b0, 32, 32'h0, d);
        `CHK(d, {4'h0, 16'h1234, 11'h055, 1'b1})
        u_tdr_dbg_host.scan(1'b1, 4, {28'h0, IR_BYPASS}, d);
        `CHK(d[3:0], IR_CAPTURE)
        u_tdr_dbg_host.scan(1'b0, 8, 32'hb5, d);
        `CHK(d[7:0], 8'h6a)
        pre = 32'h0;
        for (int i = 0; i < 8; i++)
        begin
            pre[3*i+1] = 8'h5a >> i;
            pre[3*i+2] = 8'h0f >> i;
        end
        u_tdr_dbg_host.scan(1'b1, 4, {28'h0, IR_SAMPLE}, d);
        u_tdr_dbg_host.scan(1'b0, 24, pre, d);
        for (int i = 0; i < 8; i++)
            pins[i] = d[3*i];
        `CHK(pins, 8'h3c)
        `CHK({pad_out, pad_oe}, 16'ha5ff)
        u_tdr_dbg_host.scan(1'b1, 4, {28'h0, IR_EXTEST}, d);
        `CHK({pad_out, pad_oe}, 16'h5a0f)
        @(posedge ref_clk) clk_opt_long <= 1'b1;
        u_tdr_dbg_host.scan(1'b1, 4, {28'h0, IR_CHIPRST}, d);
        u_tdr_dbg_host.scan(1'b0, 1, 32'h1, d);
        `CHK({chip_rst_hold, pad_oe}, 9'h100)
        repeat (3) @(posedge ref_clk);
        u_tdr_dbg_host.scan(1'b0, 1, 32'h0, d);
        `CHK({d[0], chip_rst_hold}, 2'b11)
        for (n = 0; n < 200 && chip_rst_hold === 1'b1; n++)
            @(posedge ref_clk) #1;
        `CHK(n >= 50 && n < 200, 1'b1)
        if (n >= 200)
            close_out();
        io_rd(IO_SYSSTAT_ADDR);
        `CHK(rsp.rdata[SYSSTAT_TAPRST_BIT], 1'b1)
        io_wr(IO_SYSSTAT_ADDR, 8'h00);
        io_rd(IO_SYSSTAT_ADDR);
        `CHK(rsp.rdata[SYSSTAT_TAPRST_BIT], 1'b0)
        io_rd(IO_MBOX_ADDR);
        `CHK(rsp.rvalid, 1'b0)
        io_rd(6'h20);
        `CHK(rsp.rvalid, 1'b0)
        @(posedge ref_clk) debug_enable_fuse <= 1'b1;
        u_tdr_dbg_host.scan(1'b1, 4, {28'h0, IR_PRIV_B}, d);
        u_tdr_dbg_host.scan(1'b0, 1, 32'h1, d);
        poll_mbox();
        io_wr(IO_MBOX_ADDR, 8'h41);
        io_rd(IO_MBOX_ADDR);
        `CHK(rsp, {8'hc1, 1'b1})
        u_tdr_dbg_host.scan(1'b1, 4, {28'h0, IR_PRIV_A}, d);
        u_tdr_dbg_host.scan(1'b0, 9, 32'h100, d);
        `CHK(d[8:0], 9'h141)
        poll_mbox();
        `CHK(rsp.rdata, 8'h41)
        for (int k = 10; k < 12; k++)
        begin
            @(posedge ref_clk) ocd_tdo <= k[0];
            u_tdr_dbg_host.scan(1'b1, 4, 32'(k), d);
            u_tdr_dbg_host.scan(1'b0, 4, 32'h0, d);
            `CHK({ocd_sel_ff, d[3:0]}, {2'(k), {4{k[0]}}})
        end
        io_wr(IO_SYSCTL_ADDR, 8'h80);
        io_wr(IO_SYSCTL_ADDR, 8'h80);
        io_rd(IO_SYSCTL_ADDR);
        `CHK(rsp, {8'h80, 1'b1})
        fuse_try(1'b1);
        @(posedge ref_clk) lock_bit_one <= 1'b1;
        fuse_try(1'b0);
        @(posedge ref_clk) lock_bit_two <= 1'b1;
        chip_erase_done <= 1'b1;
        @(posedge ref_clk) chip_erase_done <= 1'b0;
        fuse_try(1'b1);
        close_out();
    end
endmodule : tb_top
